// ### include/periph_ctrl_pkg.sv
package periph_ctrl_pkg;
    // ****************************************************************
    // Pin map and widths
    // ****************************************************************
    localparam int PIN_COUNT = 11;
    localparam int MUX_W = 8;
    localparam int ALE_PIN = 8;
    localparam int RD_PIN = 9;
    localparam int WR_PIN = 10;
    localparam int IRQ_COUNT = 2;
    localparam int PERIOD_W = 7;
    localparam int DIV_W = 16;
    localparam int CNT_W = 3;

    // ****************************************************************
    // Mode encoding and reset values
    // ****************************************************************
    localparam logic MODE_SIMPLE = 1'b0;
    localparam logic MODE_UPBUS = 1'b1;
    localparam logic [PIN_COUNT-1:0] PINS_RELEASED = 11'h7ff;
    localparam logic [PIN_COUNT-1:0] PINS_ZERO = 11'h000;
    localparam logic [MUX_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [IRQ_COUNT-1:0] IRQ_ZERO = 2'h0;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int HALF_MS_NS = 500000;
    localparam int HALF_MS_CYCLES_DEF = HALF_MS_NS / CLK_PERIOD_NS;
    localparam logic [PERIOD_W-1:0] PERIOD_MIN_MS = 7'd2;
    localparam logic [PERIOD_W-1:0] PERIOD_MAX_MS = 7'd126;
    // Cycles spent in each microprocessor bus phase, each at least one
    localparam logic [CNT_W-1:0] ALE_CYC = 3'd2;
    localparam logic [CNT_W-1:0] HOLD_CYC = 3'd1;
    localparam logic [CNT_W-1:0] STROBE_CYC = 3'd3;
    localparam logic [CNT_W-1:0] RECOVER_CYC = 3'd1;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'd1;

    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_HOLD,
        BUS_STROBE,
        BUS_RECOVER
    } bus_state_e;

    typedef struct packed {
        logic [PIN_COUNT-1:0] pin_out;
        logic [PIN_COUNT-1:0] pin_oe_n;
        logic [PIN_COUNT-1:0] rd_data;
        bus_state_e state;
        logic [CNT_W-1:0] cnt;
        logic wr;
        logic [MUX_W-1:0] wdata;
        logic [MUX_W-1:0] rdata;
        logic done;
        logic busy;
        logic [DIV_W-1:0] div;
        logic [PERIOD_W-1:0] half;
        logic wave;
        logic [IRQ_COUNT-1:0] sync1;
        logic [IRQ_COUNT-1:0] sync2;
        logic [IRQ_COUNT-1:0] prev;
        logic [IRQ_COUNT-1:0] pend;
        logic irq_oe_n;
    } ctrl_s;
endpackage

// ### src/peripheral_control_port.sv
// Summary of operation
// [RULE_01] Mode 0: eleven shared pins form a simple software read/write port.
// [RULE_02] Simple mode: each pin direction comes from a software direction vector.
// [RULE_03] Mode 1: address then data time-multiplexed on eight bidirectional pins.
// [RULE_04] Bus mode: address latch enable marks address on the multiplexed pins.
// [RULE_05] Bus mode: read strobe pulses during every external read access.
// [RULE_06] Bus mode: write strobe pulses during every external write access.
// [RULE_07] Timer output is a 50% square wave, period 2 to 126 ms.
// [RULE_08] Either edge on each external interrupt input raises a maskable request.
// [RULE_09] Pending requests drive an active-low, level, open-drain interrupt line.
// [RULE_10] Interrupt inputs pass two flip-flops before edge comparison.
module peripheral_control_port
    import periph_ctrl_pkg::*;
#(
    parameter int HALF_MS_CYCLES = HALF_MS_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic periph_bus_mode_sel,
    input wire logic [PIN_COUNT-1:0] io_dir,
    input wire logic [PIN_COUNT-1:0] io_wr_data,
    output logic [PIN_COUNT-1:0] io_rd_data,
    input wire logic [PIN_COUNT-1:0] pin_in,
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe_n,
    input wire logic bus_req,
    input wire logic bus_wr,
    input wire logic [MUX_W-1:0] bus_addr,
    input wire logic [MUX_W-1:0] bus_wdata,
    output logic [MUX_W-1:0] bus_rdata,
    output logic bus_done,
    output logic bus_busy,
    input wire logic timer_en,
    input wire logic [PERIOD_W-1:0] timer_period_ms,
    output logic second_timer_wave_out,
    input wire logic ext_irq_in_a,
    input wire logic ext_irq_in_b,
    input wire logic [IRQ_COUNT-1:0] irq_mask,
    input wire logic [IRQ_COUNT-1:0] irq_clear,
    output logic [IRQ_COUNT-1:0] irq_pending,
    output logic irq_line_out,
    output logic irq_line_oe_n
);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_MS_CYCLES - 1);

    ctrl_s st_reg;
    ctrl_s st_next;
    logic [PERIOD_W-1:0] period_clamped;

    // Out-of-range periods are pinned to the nearest legal end
    function automatic logic [PERIOD_W-1:0] clamp_period(input logic [PERIOD_W-1:0] p);
        if (p < PERIOD_MIN_MS) begin
            return PERIOD_MIN_MS;
        end else if (p > PERIOD_MAX_MS) begin
            return PERIOD_MAX_MS;
        end
        return p;
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        st_next = st_reg;
        period_clamped = clamp_period(timer_period_ms);
        if (clk_en) begin
            st_next.done = 1'b0;
            // Pin sampling into the software read vector
            st_next.rd_data = pin_in; // [RULE_01]

            // Interrupt inputs: second stage is the only reader of the first
            st_next.sync1 = {ext_irq_in_b, ext_irq_in_a}; // [RULE_10]
            st_next.sync2 = st_reg.sync1; // [RULE_10]
            st_next.prev = st_reg.sync2;
            // A change in the same cycle as a clear keeps the flag set
            st_next.pend = (st_reg.pend & ~irq_clear) | (st_reg.sync2 ^ st_reg.prev); // [RULE_08]
            st_next.irq_oe_n = ~|(st_reg.pend & irq_mask); // [RULE_09]

            // Timer: half period in half-ms units equals the period in ms
            if (!timer_en) begin
                st_next.div = '0;
                st_next.half = '0;
                st_next.wave = 1'b0;
            end else if (st_reg.div == DIV_LAST) begin
                st_next.div = '0;
                if (st_reg.half >= period_clamped - 7'd1) begin
                    st_next.half = '0;
                    st_next.wave = ~st_reg.wave; // [RULE_07]
                end else begin
                    st_next.half = st_reg.half + 7'd1;
                end
            end else begin
                st_next.div = st_reg.div + 16'd1;
            end

            if (periph_bus_mode_sel == MODE_SIMPLE) begin
                // Simple port; a mode change aborts any bus cycle quietly
                st_next.state = BUS_IDLE;
                st_next.busy = 1'b0;
                st_next.pin_out = io_wr_data; // [RULE_01]
                st_next.pin_oe_n = ~io_dir; // [RULE_02]
            end else begin
                // Bus mode: control pins always driven, idle high on strobes
                st_next.pin_oe_n[WR_PIN] = 1'b0;
                st_next.pin_oe_n[RD_PIN] = 1'b0;
                st_next.pin_oe_n[ALE_PIN] = 1'b0;
                st_next.pin_out[WR_PIN] = 1'b1;
                st_next.pin_out[RD_PIN] = 1'b1;
                st_next.pin_out[ALE_PIN] = 1'b0;
                if (st_reg.cnt > CNT_ONE) begin
                    st_next.cnt = st_reg.cnt - CNT_ONE;
                end
                case (st_reg.state)
                    BUS_IDLE: begin
                        st_next.pin_oe_n[MUX_W-1:0] = '1;
                        if (bus_req) begin
                            st_next.state = BUS_ADDR;
                            st_next.cnt = ALE_CYC;
                            st_next.wr = bus_wr;
                            st_next.wdata = bus_wdata;
                            st_next.busy = 1'b1;
                            st_next.pin_out[MUX_W-1:0] = bus_addr; // [RULE_03]
                            st_next.pin_oe_n[MUX_W-1:0] = '0;
                            st_next.pin_out[ALE_PIN] = 1'b1; // [RULE_04]
                        end
                    end
                    BUS_ADDR: begin
                        st_next.pin_out[ALE_PIN] = 1'b1; // [RULE_04]
                        if (st_reg.cnt == CNT_ONE) begin
                            // Address stays on the pins past the falling latch edge
                            st_next.pin_out[ALE_PIN] = 1'b0;
                            st_next.state = BUS_HOLD;
                            st_next.cnt = HOLD_CYC;
                        end
                    end
                    BUS_HOLD: begin
                        if (st_reg.cnt == CNT_ONE) begin
                            st_next.state = BUS_STROBE;
                            st_next.cnt = STROBE_CYC;
                            if (st_reg.wr) begin
                                st_next.pin_out[MUX_W-1:0] = st_reg.wdata; // [RULE_03]
                                st_next.pin_out[WR_PIN] = 1'b0; // [RULE_06]
                            end else begin
                                st_next.pin_oe_n[MUX_W-1:0] = '1; // [RULE_03]
                                st_next.pin_out[RD_PIN] = 1'b0; // [RULE_05]
                            end
                        end
                    end
                    BUS_STROBE: begin
                        st_next.pin_out[WR_PIN] = ~st_reg.wr; // [RULE_06]
                        st_next.pin_out[RD_PIN] = st_reg.wr; // [RULE_05]
                        if (st_reg.cnt == CNT_ONE) begin
                            st_next.pin_out[WR_PIN] = 1'b1;
                            st_next.pin_out[RD_PIN] = 1'b1;
                            // Read data taken on the last strobe-low cycle
                            if (!st_reg.wr) begin
                                st_next.rdata = pin_in[MUX_W-1:0]; // [RULE_03]
                            end
                            st_next.state = BUS_RECOVER;
                            st_next.cnt = RECOVER_CYC;
                        end
                    end
                    BUS_RECOVER: begin
                        st_next.pin_oe_n[MUX_W-1:0] = '1;
                        if (st_reg.cnt == CNT_ONE) begin
                            st_next.state = BUS_IDLE;
                            st_next.busy = 1'b0;
                            st_next.done = 1'b1;
                        end
                    end
                    default: begin
                        st_next.state = BUS_IDLE;
                        st_next.busy = 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{
                pin_out: PINS_ZERO, pin_oe_n: PINS_RELEASED, rd_data: PINS_ZERO,
                state: BUS_IDLE, cnt: '0, wr: 1'b0, wdata: BYTE_ZERO, rdata: BYTE_ZERO,
                done: 1'b0, busy: 1'b0, div: '0, half: '0, wave: 1'b0,
                sync1: IRQ_ZERO, sync2: IRQ_ZERO, prev: IRQ_ZERO, pend: IRQ_ZERO,
                irq_oe_n: 1'b1
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register, except irq_line_out which is tied low
    assign io_rd_data = st_reg.rd_data;
    assign pin_out = st_reg.pin_out;
    assign pin_oe_n = st_reg.pin_oe_n;
    assign bus_rdata = st_reg.rdata;
    assign bus_done = st_reg.done;
    assign bus_busy = st_reg.busy;
    assign second_timer_wave_out = st_reg.wave;
    assign irq_pending = st_reg.pend;
    assign irq_line_out = 1'b0; // Open drain: only the enable ever moves
    assign irq_line_oe_n = st_reg.irq_oe_n;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Sampled reset in each trigger: the flops still take reset on the release edge
    sequence req_taken;
        rst_n && clk_en && periph_bus_mode_sel && st_reg.state == BUS_IDLE && bus_req;
    endsequence
    sequence strobe_entry;
        rst_n && clk_en && periph_bus_mode_sel && st_reg.state == BUS_HOLD && st_reg.cnt == CNT_ONE;
    endsequence

    a_simple_dir_follow: assert property (rst_n && clk_en && !periph_bus_mode_sel // [RULE_02]
        |=> pin_oe_n == ~$past(io_dir))
        else $error("simple mode direction not applied");
    a_simple_read_sample: assert property (rst_n && clk_en |=> io_rd_data == $past(pin_in)) // [RULE_01]
        else $error("read vector not sampled");
    a_bus_ale_start: assert property (req_taken // [RULE_04]
        |=> pin_out[ALE_PIN] && !pin_oe_n[ALE_PIN] ##1 pin_out[ALE_PIN])
        else $error("address latch pulse missing");
    a_bus_addr_drive: assert property (req_taken // [RULE_03]
        |=> pin_out[MUX_W-1:0] == $past(bus_addr) && pin_oe_n[MUX_W-1:0] == '0)
        else $error("address not driven");
    a_read_strobe_low: assert property ((strobe_entry and !st_reg.wr) // [RULE_05]
        |=> !pin_out[RD_PIN] && pin_oe_n[MUX_W-1:0] == '1)
        else $error("read strobe not asserted");
    a_write_strobe_low: assert property ((strobe_entry and st_reg.wr) // [RULE_06]
        |=> !pin_out[WR_PIN] && pin_oe_n[MUX_W-1:0] == '0)
        else $error("write strobe not asserted");
    a_wave_toggle_cause: assert property ($changed(second_timer_wave_out) // [RULE_07]
        |-> $past(timer_en) && $past(st_reg.div) == DIV_LAST)
        else $error("timer wave toggled off a half-ms boundary");
    a_sync_chain: assert property (rst_n && clk_en |=> st_reg.sync2 == $past(st_reg.sync1)) // [RULE_10]
        else $error("sync stages out of order");
    a_irq_edge_set: assert property (rst_n && clk_en && (st_reg.sync2[0] != st_reg.prev[0]) // [RULE_08]
        |=> irq_pending[0])
        else $error("edge on input a not latched");
    a_irq_line_low: assert property (rst_n && clk_en && |(irq_pending & irq_mask) |=> !irq_line_oe_n) // [RULE_09]
        else $error("interrupt line not pulled low");
endmodule

// ### dv/periph_bus_partner.sv
// ************************************************************
// Peripheral on the shared pins
// ************************************************************
module periph_bus_partner
    import periph_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic bus_mode,
    input wire logic [PIN_COUNT-1:0] pin_out,
    input wire logic [PIN_COUNT-1:0] pin_oe_n,
    output logic [PIN_COUNT-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [MUX_W-1:0] mem [256];
    logic [MUX_W-1:0] addr_q = 8'h00;
    logic [PIN_COUNT-1:0] pat = 11'h155;
    logic rd_on;

    // Known contents so a read of an unwritten byte is predictable
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end

    // Released pins wander every cycle, so a stale sample never passes
    always @(posedge clk) begin
        pat <= pat + 11'h2b5;
        if (bus_mode && pin_out[ALE_PIN]) begin
            addr_q <= pin_in[MUX_W-1:0];
        end
        if (bus_mode && !pin_oe_n[WR_PIN] && !pin_out[WR_PIN]) begin
            mem[addr_q] <= pin_in[MUX_W-1:0];
        end
    end

    // Wire level from both parties' drivers
    assign rd_on = bus_mode && !pin_oe_n[RD_PIN] && !pin_out[RD_PIN];
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            pin_in[i] = pin_oe_n[i] ? pat[i] : pin_out[i];
        end
        if (rd_on) begin
            pin_in[MUX_W-1:0] = mem[addr_q];
        end
    end
endmodule

// ### dv/peripheral_control_port_tb_top.sv
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
// ************************************************************
// Bench for the peripheral control port
// ************************************************************
module peripheral_control_port_tb_top
    import periph_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 4;
    logic clk, rst_n, clk_en, mode, bus_req, bus_wr, timer_en, bus_done, busy, wave, line_oe_n, line_out;
    logic [PIN_COUNT-1:0] io_dir, io_wr_data, io_rd_data, pin_in, pin_out, pin_oe_n;
    logic [MUX_W-1:0] bus_addr, bus_wdata, bus_rdata;
    logic [PERIOD_W-1:0] timer_period_ms;
    logic [1:0] irq_in, irq_mask, irq_clear, irq_pending;
    logic [MUX_W-1:0] mdl [256];
    logic [MUX_W-1:0] adr [4];
    int periods [5] = '{1, 2, 5, 126, 127};
    int num_errors = 0;
    int n_checks = 0;

    peripheral_control_port #(.HALF_MS_CYCLES(HALF)) peripheral_control_port_inst (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .periph_bus_mode_sel(mode),
        .io_dir(io_dir), .io_wr_data(io_wr_data), .io_rd_data(io_rd_data),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .bus_req(bus_req), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_done(bus_done), .bus_busy(busy),
        .timer_en(timer_en), .timer_period_ms(timer_period_ms), .second_timer_wave_out(wave),
        .ext_irq_in_a(irq_in[0]), .ext_irq_in_b(irq_in[1]), .irq_mask(irq_mask),
        .irq_clear(irq_clear), .irq_pending(irq_pending), .irq_line_out(line_out),
        .irq_line_oe_n(line_oe_n));
    periph_bus_partner periph_bus_partner_inst (
        .clk(clk), .bus_mode(mode), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));

    // Clock at 40 MHz
    always #12.5 clk = ~clk;

    task automatic conclude();
        if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // One access; strobe widths are counted, read data is checked against the model
    task automatic bus_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        int ale = 0;
        int rs = 0;
        int ws = 0;
        int bz = 0;
        @(posedge clk);
        bus_req <= 1'b1;
        bus_wr <= wr;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_req <= 1'b0;
        repeat (12) begin
            #1;
            if (bus_done === 1'b1) break;
            ale += int'(pin_out[ALE_PIN]);
            rs += int'(!pin_out[RD_PIN]);
            ws += int'(!pin_out[WR_PIN]);
            bz += int'(busy);
            @(posedge clk);
            n++;
        end
        // Done shows once every phase has run, counted from the accepting edge
        `CHK(n, ALE_CYC + HOLD_CYC + STROBE_CYC + RECOVER_CYC)
        `CHK(bz, ALE_CYC + HOLD_CYC + STROBE_CYC + RECOVER_CYC)
        `CHK(busy, 1'b0)
        `CHK(ale, ALE_CYC)
        `CHK(rs, wr ? 0 : STROBE_CYC)
        `CHK(ws, wr ? STROBE_CYC : 0)
        if (wr) mdl[a] = d;
        else `CHK(bus_rdata, mdl[a])
    endtask

    // Half period measured between two edges of the wave
    task automatic timer_run(input int p);
        int n = 0;
        int want;
        want = (p < 2 ? 2 : (p > 126 ? 126 : p)) * HALF;
        @(posedge clk);
        timer_period_ms <= 7'(p);
        timer_en <= 1'b1;
        repeat (1200) begin
            @(posedge clk);
            #1;
            if (wave === 1'b1) break;
        end
        while (wave === 1'b1 && n < 1200) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(n, want)
        @(posedge clk);
        timer_en <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK(wave, 1'b0)
    endtask

    // Toggle one input masked, then unmask, then clear
    task automatic irq_step(input int b);
        logic [1:0] m;
        m = 2'b01 << b;
        @(posedge clk);
        irq_mask <= 2'b00;
        irq_in <= irq_in ^ m;
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq_pending, 2'b00)
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq_pending, m)
        `CHK(line_oe_n, 1'b1)
        @(posedge clk);
        irq_mask <= m;
        repeat (2) @(posedge clk);
        #1;
        `CHK(line_oe_n, 1'b0)
        `CHK(line_out, 1'b0)
        @(posedge clk);
        irq_clear <= m;
        @(posedge clk);
        irq_clear <= 2'b00;
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq_pending, 2'b00)
        `CHK(line_oe_n, 1'b1)
    endtask

    // Main sequence: simple port, bus accesses, timer, interrupts
    initial begin
        logic [PIN_COUNT-1:0] d, w, exp;
        clk = 0; rst_n = 0; mode = 0; bus_req = 0; bus_wr = 0; timer_en = 0;
        clk_en = 1'b1;
        io_dir = '0; io_wr_data = '0; bus_addr = '0; bus_wdata = '0;
        timer_period_ms = 7'h02; irq_in = '0; irq_mask = '0; irq_clear = '0;
        for (int i = 0; i < 256; i++) mdl[i] = 8'(i) ^ 8'h5a;
        void'($urandom(32'h0313));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) begin
            @(posedge clk);
            d = 11'($urandom);
            w = 11'($urandom);
            io_dir <= d;
            io_wr_data <= w;
            @(posedge clk);
            #1;
            exp = pin_in;
            @(posedge clk);
            #1;
            `CHK(pin_oe_n, ~d)
            `CHK(pin_out, w)
            `CHK(io_rd_data, exp)
        end
        // Clock enable low must hold the pins while new data waits
        @(posedge clk);
        clk_en <= 1'b0;
        io_wr_data <= ~w;
        repeat (3) @(posedge clk);
        #1;
        `CHK(pin_out, w)
        @(posedge clk);
        clk_en <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK(pin_out, ~w)
        @(posedge clk);
        mode <= 1'b1;
        io_dir <= '0;
        foreach (adr[i]) begin
            adr[i] = 8'($urandom);
            bus_op(1'b1, adr[i], 8'($urandom));
        end
        foreach (adr[i]) bus_op(1'b0, adr[i], 8'h00);
        bus_op(1'b0, 8'($urandom), 8'h00);
        foreach (periods[i]) timer_run(periods[i]);
        for (int k = 0; k < 4; k++) irq_step(k % 2);
        conclude();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        conclude();
    end
endmodule
